// File: rtl/qbx_pkg.sv
// constants and types shared by both ends of the quasi-bidirectional expander link
// ----------------------------------------------------------------------------
// Functional notes
// RL1: master sends address byte, msb first, direction last
// RL2: direction bit one reads, zero writes
// RL3: each strap decodes four ways, 64 addresses
// RL4: respond only to the strap-mapped address
// RL5: latch high is weak input, low drives
// RL6: all port latches high after reset
// RL7: strong pull-up on high write until scl falls
// RL8: ack address and bytes, ports a b c
// RL9: byte reaches pins only after its ack; the code latches it at the scl fall that starts the ack clock
// RL10: unlimited write bytes, wrap every third
// RL11: read returns live pins, three byte groups
// RL12: master writes ones before reading inputs
// RL13: stop may end read at any byte
// RL14: capture port at ack before byte, msb first
// RL15: interrupt low on any input edge
// RL16: interrupt released on restore, read or write
// RL17: reset holds latches and bus logic default
// ----------------------------------------------------------------------------
package qbx_pkg;
    localparam int QBX_PORTS = 3;
    localparam int QBX_WIDTH = 8;
    localparam logic [7:0] QBX_LATCH_RESET = 8'hff;
    localparam logic [1:0] QBX_STRAP_GND = 2'h0;
    localparam logic [1:0] QBX_STRAP_VDD = 2'h1;
    localparam logic [1:0] QBX_STRAP_SCL = 2'h2;
    localparam logic [1:0] QBX_STRAP_SDA = 2'h3;
    localparam int QBX_CLK_MHZ = 50;
    localparam int QBX_SCL_KHZ = 100;
    // quarter period of the generated scl in system clocks
    localparam int QBX_SCL_HALF = (QBX_CLK_MHZ * 1000) / (QBX_SCL_KHZ * 2);
    typedef enum logic [2:0] {
        QBX_S_IDLE = 3'h0,
        QBX_S_ADDR = 3'h1,
        QBX_S_ACK = 3'h3,
        QBX_S_DATA = 3'h2,
        QBX_S_SKIP = 3'h6
    } qbx_state_t;
endpackage

// File: rtl/qbx_link_if.sv
// two-wire link between master and expander, plus reset and interrupt
`timescale 1ns/10ps
`default_nettype none
interface qbx_link_if;
    logic scl_o;
    logic scl_oe_n;
    logic sda_m_o;
    logic sda_m_oe_n;
    logic sda_s_o;
    logic sda_s_oe_n;
    logic int_o;
    logic int_oe_n;
    logic reset_n;
    logic scl;
    logic sda;
    logic int_line_n;
    // open-drain resolution with pull-ups
    assign scl = scl_oe_n ? 1'b1 : scl_o;
    assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);
    assign int_line_n = int_oe_n ? 1'b1 : int_o;
    modport dev (input scl, input sda, input reset_n, output sda_s_o, output sda_s_oe_n,
        output int_o, output int_oe_n);
    modport host (input scl, input sda, input int_line_n, output scl_o, output scl_oe_n,
        output sda_m_o, output sda_m_oe_n, output reset_n);
endinterface
`default_nettype wire

// File: rtl/qbx_expander.sv
// expander end: serial slave, three quasi-bidirectional ports, interrupt
`timescale 1ns/10ps
`default_nettype none
module qbx_expander
    import qbx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    qbx_link_if.dev link,
    input wire logic [1:0] addr_strap_low,
    input wire logic [1:0] addr_strap_mid,
    input wire logic [1:0] addr_strap_high,
    input wire logic [23:0] port_pins_in,
    output logic [7:0] port_a_pins,
    output logic [7:0] port_b_pins,
    output logic [7:0] port_c_pins,
    output logic [23:0] strong_pullup_current,
    output logic [23:0] port_drive_low
);
    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    logic [2:0] sync1, sync2, prev;
    logic [23:0] pin_s1, pin_s2;
    logic [5:0] strap_s1, strap_s2;
    always_ff @(posedge clk) begin
        sync1 <= {link.scl, link.sda, link.reset_n};
        sync2 <= sync1;
        pin_s1 <= port_pins_in;
        pin_s2 <= pin_s1;
        strap_s1 <= {addr_strap_high, addr_strap_mid, addr_strap_low};
        strap_s2 <= strap_s1;
    end
    wire scl = sync2[2];
    wire sda = sync2[1];
    // pin reset and rst_n both hold state at default
    wire hold = !rst_n || !sync2[0]; // see RL17
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev <= 3'h7;
        end else begin
            prev <= sync2;
        end
    end
    wire scl_rise = scl && !prev[2];
    wire scl_fall = !scl && prev[2];
    wire start_c = scl && prev[2] && !sda && prev[1];
    wire stop_c = scl && prev[2] && sda && !prev[1];
    // ------------------------------------------------------------------------
    // address decode from straps
    // ------------------------------------------------------------------------
    logic [6:0] my_addr;
    always_comb begin
        // see RL3 RL4
        logic [1:0] h, m, l;
        h = strap_s2[5:4];
        m = strap_s2[3:2];
        l = strap_s2[1:0];
        my_addr = 7'h00;
        if (!h[1] && !m[1] && !l[1]) begin
            my_addr = {4'h4, h[0], m[0], l[0]};
        end else if (!h[1] && m[1] && !l[1]) begin
            my_addr = {4'h2, h[0], m[0], l[0]};
        end else if (!h[1] && m[1] && l[1]) begin
            my_addr = {4'h3, h[0], m[0], l[0]};
        end else if (!h[1] && !m[1] && l[1]) begin
            my_addr = {4'h5, h[0], m[0], l[0]};
        end else if (h[1] && m[1]) begin
            my_addr = {3'h5, l[1], h[0], m[0], l[0]};
        end else if (h[1] && !l[1]) begin
            my_addr = {4'hc, h[0], m[0], l[0]};
        end else begin
            my_addr = {4'he, h[0], m[0], l[0]};
        end
    end
    // ------------------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------------------
    qbx_state_t state;
    logic [2:0] bitn;
    logic [7:0] shreg;
    // ack_clk marks the ninth scl pulse, which carries no data bit
    logic is_addr, rd_mode, ack_ok, ack_clk;
    logic [1:0] port_idx;
    logic [7:0] latch [QBX_PORTS];
    logic wr_strobe, rd_strobe;
    logic [23:0] hi_written;
    wire [7:0] pins_now [QBX_PORTS] = '{pin_s2[7:0], pin_s2[15:8], pin_s2[23:16]};
    always_ff @(posedge clk) begin
        wr_strobe <= 1'b0;
        rd_strobe <= 1'b0;
        hi_written <= 24'h0;
        if (hold) begin
            state <= QBX_S_IDLE;
            bitn <= 3'h0;
            shreg <= 8'h00;
            is_addr <= 1'b0;
            rd_mode <= 1'b0;
            ack_ok <= 1'b0;
            ack_clk <= 1'b0;
            port_idx <= 2'h0;
            for (int i = 0; i < QBX_PORTS; i++) latch[i] <= QBX_LATCH_RESET; // see RL6
        end else if (start_c) begin
            state <= QBX_S_ADDR;
            bitn <= 3'h0;
            is_addr <= 1'b1;
            ack_clk <= 1'b0;
        end else if (stop_c) begin
            state <= QBX_S_IDLE; // see RL13
        end else begin
            unique case (state)
                QBX_S_IDLE, QBX_S_SKIP: ;
                QBX_S_ADDR: if (scl_fall) begin
                    ack_clk <= 1'b0;
                end else if (scl_rise && !ack_clk) begin
                    shreg <= {shreg[6:0], sda}; // see RL1
                    bitn <= bitn + 3'h1;
                    if (bitn == 3'h7) state <= QBX_S_ACK;
                end
                QBX_S_ACK: if (scl_fall) begin
                    if (is_addr) begin
                        // see RL2 RL4 RL8
                        ack_ok <= shreg[7:1] == my_addr;
                        rd_mode <= shreg[0];
                        port_idx <= 2'h0;
                        is_addr <= 1'b0;
                        if (shreg[7:1] != my_addr) state <= QBX_S_SKIP;
                        else if (shreg[0]) begin
                            state <= QBX_S_DATA;
                            shreg <= pins_now[0]; // see RL11 RL14
                            rd_strobe <= 1'b1;
                        end else state <= QBX_S_ACK;
                        // write: back to the address state, ack_clk keeps the ack bit out of the shift
                        if (shreg[7:1] == my_addr && !shreg[0]) state <= QBX_S_ADDR;
                        bitn <= 3'h0;
                        ack_clk <= 1'b1;
                    end else if (!rd_mode) begin
                        // latch at the scl fall that starts the ack clock, as the ack is driven
                        latch[port_idx] <= shreg; // see RL9
                        hi_written[port_idx*8 +: 8] <= shreg; // see RL7
                        port_idx <= (port_idx == 2'h2) ? 2'h0 : port_idx + 2'h1; // see RL10
                        wr_strobe <= 1'b1; // see RL16
                        state <= QBX_S_ADDR;
                        ack_clk <= 1'b1;
                    end else begin
                        // master ack low continues the read, nack ends it
                        if (sda) state <= QBX_S_SKIP;
                        else begin
                            shreg <= pins_now[port_idx]; // see RL14
                            rd_strobe <= 1'b1; // see RL16
                            state <= QBX_S_DATA;
                        end
                    end
                end
                QBX_S_DATA: if (scl_fall && ack_clk) begin
                    ack_clk <= 1'b0;
                end else if (scl_fall) begin
                    shreg <= {shreg[6:0], 1'b0};
                    bitn <= bitn + 3'h1;
                    if (bitn == 3'h7) begin
                        state <= QBX_S_ACK;
                        port_idx <= (port_idx == 2'h2) ? 2'h0 : port_idx + 2'h1; // see RL11
                    end
                end
                default: state <= QBX_S_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------------------
    // sda drive: ack low during ack clock, data msb first in read
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (hold) begin
            link.sda_s_o <= 1'b1;
            link.sda_s_oe_n <= 1'b1;
        end else if (state == QBX_S_ADDR && bitn == 3'h7 && scl_rise) begin
            link.sda_s_o <= 1'b1;
            link.sda_s_oe_n <= 1'b1;
        end else if (state == QBX_S_ACK && scl_fall && (!rd_mode || is_addr)) begin
            link.sda_s_o <= !((is_addr && shreg[7:1] == my_addr) || (!is_addr && ack_ok));
            link.sda_s_oe_n <= !((is_addr && shreg[7:1] == my_addr) || (!is_addr && ack_ok));
        end else if (state == QBX_S_ACK && scl_fall && rd_mode && !is_addr) begin
            link.sda_s_o <= 1'b1;
            link.sda_s_oe_n <= 1'b1;
        end else if (state == QBX_S_DATA && !ack_clk) begin
            link.sda_s_o <= shreg[7]; // see RL14
            link.sda_s_oe_n <= shreg[7];
            if (bitn == 3'h7 && scl_fall) begin
                link.sda_s_o <= 1'b1;
                link.sda_s_oe_n <= 1'b1;
            end
        end else if (state == QBX_S_ADDR && !is_addr && scl_fall) begin
            link.sda_s_o <= 1'b1;
            link.sda_s_oe_n <= 1'b1;
        end else if (state == QBX_S_IDLE || state == QBX_S_SKIP) begin
            link.sda_s_o <= 1'b1;
            link.sda_s_oe_n <= 1'b1;
        end
    end
    // ------------------------------------------------------------------------
    // port outputs and strong pull-up
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 24; g++) begin : g_pin
            always_ff @(posedge clk) begin
                if (hold) begin
                    strong_pullup_current[g] <= 1'b0;
                    port_drive_low[g] <= 1'b0;
                end else begin
                    port_drive_low[g] <= !latch[g/8][g%8]; // see RL5
                    if (hi_written[g]) strong_pullup_current[g] <= 1'b1; // see RL7
                    else if (scl_fall) strong_pullup_current[g] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (hold) begin
            port_a_pins <= QBX_LATCH_RESET;
            port_b_pins <= QBX_LATCH_RESET;
            port_c_pins <= QBX_LATCH_RESET;
        end else begin
            port_a_pins <= latch[0];
            port_b_pins <= latch[1];
            port_c_pins <= latch[2];
        end
    end
    // ------------------------------------------------------------------------
    // interrupt on change
    // ------------------------------------------------------------------------
    logic [23:0] ref_lvl;
    always_ff @(posedge clk) begin
        if (hold) begin
            ref_lvl <= 24'hffffff;
            link.int_o <= 1'b1;
            link.int_oe_n <= 1'b1;
        end else begin
            if (wr_strobe || rd_strobe) ref_lvl <= pin_s2; // see RL16
            // differs from reference: edge seen; equal again: released
            link.int_o <= !(pin_s2 != ref_lvl && !wr_strobe && !rd_strobe); // see RL15
            link.int_oe_n <= !(pin_s2 != ref_lvl && !wr_strobe && !rd_strobe);
        end
    end
endmodule // qbx_expander
`default_nettype wire

// File: rtl/qbx_master.sv
// master end: generates scl, sends address, writes or reads a byte stream
`timescale 1ns/10ps
`default_nettype none
module qbx_master
    import qbx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    qbx_link_if.host link,
    input wire logic go,
    input wire logic [6:0] dev_addr,
    input wire logic read,
    input wire logic [7:0] nbytes,
    input wire logic [7:0] wr_data,
    input wire logic dev_reset_n,
    output logic wr_take,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic busy,
    output logic nacked,
    output logic irq_seen
);
    logic [1:0] sda_s, int_s;
    always_ff @(posedge clk) begin
        sda_s <= {sda_s[0], link.sda};
        int_s <= {int_s[0], link.int_line_n};
    end
    typedef enum logic [2:0] {
        QBX_M_IDLE = 3'h0, QBX_M_START = 3'h1, QBX_M_BIT = 3'h3,
        QBX_M_ACK = 3'h2, QBX_M_STOP = 3'h6
    } qbx_mstate_t;
    qbx_mstate_t st;
    logic [15:0] tick;
    logic [1:0] phase;
    logic [2:0] bitn;
    logic [7:0] sh, left;
    logic first, rd;
    wire half = tick == 16'(QBX_SCL_HALF - 1);
    always_ff @(posedge clk) begin
        wr_take <= 1'b0;
        rd_valid <= 1'b0;
        if (!rst_n) begin
            st <= QBX_M_IDLE;
            tick <= 16'h0;
            phase <= 2'h0;
            bitn <= 3'h0;
            sh <= 8'h00;
            left <= 8'h00;
            first <= 1'b0;
            rd <= 1'b0;
            busy <= 1'b0;
            nacked <= 1'b0;
            rd_data <= 8'h00;
            irq_seen <= 1'b0;
            link.scl_o <= 1'b1;
            link.scl_oe_n <= 1'b1;
            link.sda_m_o <= 1'b1;
            link.sda_m_oe_n <= 1'b1;
            link.reset_n <= 1'b0;
        end else begin
            link.reset_n <= dev_reset_n;
            irq_seen <= !int_s[1];
            tick <= half ? 16'h0 : tick + 16'h1;
            unique case (st)
                QBX_M_IDLE: if (go) begin
                    st <= QBX_M_START;
                    sh <= {dev_addr, read}; // see RL1 RL2
                    rd <= read;
                    left <= nbytes;
                    first <= 1'b1;
                    busy <= 1'b1;
                    nacked <= 1'b0;
                    tick <= 16'h0;
                end
                QBX_M_START: if (half) begin
                    link.sda_m_o <= 1'b0;
                    link.sda_m_oe_n <= 1'b0;
                    st <= QBX_M_BIT;
                    phase <= 2'h0;
                    bitn <= 3'h0;
                end
                QBX_M_BIT, QBX_M_ACK: if (half) begin
                    phase <= phase + 2'h1;
                    if (phase == 2'h0) begin
                        link.scl_o <= 1'b0;
                        link.scl_oe_n <= 1'b0;
                    end else if (phase == 2'h1) begin
                        // data changes while scl low
                        if (st == QBX_M_BIT) begin
                            link.sda_m_o <= (rd && !first) ? 1'b1 : sh[7];
                            link.sda_m_oe_n <= (rd && !first) ? 1'b1 : sh[7];
                        end else begin
                            link.sda_m_o <= !(rd && !first && left != 8'h0); // see RL13
                            link.sda_m_oe_n <= !(rd && !first && left != 8'h0);
                        end
                    end else if (phase == 2'h2) begin
                        link.scl_oe_n <= 1'b1;
                        link.scl_o <= 1'b1;
                    end else if (st == QBX_M_BIT) begin
                        sh <= {sh[6:0], sda_s[1]};
                        bitn <= bitn + 3'h1;
                        if (bitn == 3'h7) st <= QBX_M_ACK;
                        if (bitn == 3'h7 && rd && !first) begin
                            rd_data <= {sh[6:0], sda_s[1]};
                            rd_valid <= 1'b1;
                            left <= left - 8'h1;
                        end
                    end else begin
                        if ((first || !rd) && sda_s[1]) nacked <= 1'b1;
                        if (!first && !rd) left <= left - 8'h1;
                        first <= 1'b0;
                        if (((first || !rd) && sda_s[1]) || left == 8'h0
                            || (!first && !rd && left == 8'h1)) st <= QBX_M_STOP;
                        else begin
                            st <= QBX_M_BIT;
                            sh <= wr_data; // see RL8
                            wr_take <= !rd;
                        end
                    end
                end
                QBX_M_STOP: if (half) begin
                    phase <= phase + 2'h1;
                    if (phase == 2'h0) begin
                        link.scl_o <= 1'b0;
                        link.scl_oe_n <= 1'b0;
                    end else if (phase == 2'h1) begin
                        link.sda_m_o <= 1'b0;
                        link.sda_m_oe_n <= 1'b0;
                    end else if (phase == 2'h2) begin
                        link.scl_oe_n <= 1'b1;
                        link.scl_o <= 1'b1;
                    end else begin
                        link.sda_m_o <= 1'b1;
                        link.sda_m_oe_n <= 1'b1;
                        busy <= 1'b0;
                        st <= QBX_M_IDLE;
                    end
                end
                default: st <= QBX_M_IDLE;
            endcase
        end
    end
endmodule // qbx_master
`default_nettype wire

// File: sim/qbx_link_props.sv
// assertions on the expander link, interrupt line and port outputs
`timescale 1ns/10ps
`default_nettype none
module qbx_link_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_o,
    input wire logic sda_s_oe_n,
    input wire logic int_line_n,
    input wire logic reset_n,
    input wire logic [23:0] port_pins_in,
    input wire logic [7:0] port_a_pins,
    input wire logic [7:0] port_b_pins,
    input wire logic [7:0] port_c_pins,
    input wire logic [23:0] strong_pullup_current,
    input wire logic [23:0] port_drive_low
);
    // --------
    // helper logic
    // --------
    logic [23:0] lat;
    logic [9:0] pu_cnt;
    logic [10:0] idle_cnt;
    assign lat = {port_c_pins, port_b_pins, port_a_pins};
    // cycles a strong pull-up has outlived an scl fall
    always_ff @(posedge clk) begin
        if (!rst_n || strong_pullup_current == 24'h0) begin
            pu_cnt <= 10'h0;
        end else if (pu_cnt != 10'h0 || $fell(scl)) begin
            pu_cnt <= pu_cnt + 10'h1;
        end
    end
    // cycles of idle bus with quiet pins
    always_ff @(posedge clk) begin
        if (!rst_n || !reset_n || !scl || !sda || $changed(port_pins_in)) begin
            idle_cnt <= 11'h0;
        end else if (idle_cnt != 11'h7ff) begin
            idle_cnt <= idle_cnt + 11'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // --------
    // assertions
    // --------
    reset_latch_a: assert property (!reset_n [*8] |-> lat == 24'hffffff)
        else $error("latches not high in link reset");
    reset_release_a: assert property (!reset_n [*8] |-> int_line_n && (sda_s_oe_n | sda_s_o))
        else $error("lines held in link reset");
    drive_low_a: assert property (lat == $past(lat) && lat == $past(lat, 2)
        |-> port_drive_low == ~lat)
        else $error("drive low differs from latch");
    pullup_off_a: assert property (pu_cnt < 10'h8)
        else $error("strong pull-up kept past scl fall");
    sda_change_a: assert property ($changed(sda_s_oe_n | sda_s_o) |-> !scl)
        else $error("expander moved sda while scl high");
    int_edge_a: assert property (int_line_n && scl && sda && $changed(port_pins_in)
        |-> ##[1:8] !int_line_n)
        else $error("pin change raised no interrupt");
    int_hold_a: assert property (idle_cnt > 11'h400 && !int_line_n |=> !int_line_n)
        else $error("interrupt dropped without cause");
    start_hold_a: assert property ($fell(sda) && scl |=> scl [*8])
        else $error("scl fell right after start");
    cover property ($fell(int_line_n));
    cover property (pu_cnt == 10'h1);
    cover property (!reset_n [*8]);
    cover property (!(sda_s_oe_n | sda_s_o) && scl);
endmodule // qbx_link_props
`default_nettype wire

// File: sim/i2c_quasi_bidir_port_expander_24_tb.sv
// self-checking bench: master and expander joined over the link
`timescale 1ns/10ps
`default_nettype none
module i2c_quasi_bidir_port_expander_24_tb;
    logic clk = 1'b0;
    logic rst_n;
    logic go;
    logic [6:0] dev_addr;
    logic read;
    logic [7:0] nbytes;
    logic [7:0] wr_data;
    logic dev_reset_n;
    logic [1:0] strap_lo, strap_mid, strap_hi;
    logic [23:0] port_pins_in;
    logic wr_take, rd_valid, busy, nacked, irq_seen, int_line_n;
    logic [7:0] rd_data, port_a_pins, port_b_pins, port_c_pins;
    logic [23:0] strong_pullup_current, port_drive_low, lat;
    logic [23:0] pu_or = 24'h0;
    logic [31:0] seed = 32'h2a;
    logic [7:0] wbuf [4];
    logic [7:0] rq [$];
    logic [6:0] own;
    int widx = 0;
    int errors = 0;
    int checked = 0;
    always #10 clk = ~clk;
    assign lat = {port_c_pins, port_b_pins, port_a_pins};
    assign int_line_n = u_qbx_link_if.int_line_n;
    // --------
    // design and checker
    // --------
    qbx_link_if u_qbx_link_if ();
    qbx_master u_qbx_master (
        .clk(clk), .rst_n(rst_n), .link(u_qbx_link_if), .go(go), .dev_addr(dev_addr),
        .read(read), .nbytes(nbytes), .wr_data(wr_data), .dev_reset_n(dev_reset_n),
        .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
        .nacked(nacked), .irq_seen(irq_seen)
    );
    qbx_expander u_qbx_expander (
        .clk(clk), .rst_n(rst_n), .link(u_qbx_link_if), .addr_strap_low(strap_lo),
        .addr_strap_mid(strap_mid), .addr_strap_high(strap_hi), .port_pins_in(port_pins_in),
        .port_a_pins(port_a_pins), .port_b_pins(port_b_pins), .port_c_pins(port_c_pins),
        .strong_pullup_current(strong_pullup_current), .port_drive_low(port_drive_low)
    );
    qbx_link_props u_qbx_link_props (
        .clk(clk), .rst_n(rst_n), .scl(u_qbx_link_if.scl), .sda(u_qbx_link_if.sda),
        .sda_s_o(u_qbx_link_if.sda_s_o), .sda_s_oe_n(u_qbx_link_if.sda_s_oe_n),
        .int_line_n(int_line_n), .reset_n(u_qbx_link_if.reset_n),
        .port_pins_in(port_pins_in), .port_a_pins(port_a_pins), .port_b_pins(port_b_pins),
        .port_c_pins(port_c_pins), .strong_pullup_current(strong_pullup_current),
        .port_drive_low(port_drive_low)
    );
    // --------
    // helpers
    // --------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // bit 1 of a strap code marks a tie to scl or sda
    function automatic logic [6:0] addr_of(input logic [1:0] h, input logic [1:0] m,
        input logic [1:0] l);
        logic [31:0] nib;
        nib = 32'hbaec3254 >> {h[1], m[1], l[1], 2'h0};
        return {nib[3:0], h[0], m[0], l[0]};
    endfunction
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] n);
        int k;
        widx = 0;
        @(negedge clk);
        dev_addr = a;
        read = rd;
        nbytes = n;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        k = 0;
        while (busy !== 1'b1 && k < 4) begin
            @(negedge clk);
            k++;
        end
        while (busy !== 1'b0 && k < 60000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 60000) begin
            errors++;
        end
    endtask
    // move some pins and let the interrupt settle on an idle bus
    task automatic flip();
        logic [31:0] r;
        r = rnd();
        @(negedge clk);
        port_pins_in = port_pins_in ^ (r[23:0] | 24'h1);
        repeat (1500) @(negedge clk);
        chk(24'(int_line_n), 24'h0);
    endtask
    // next write byte after each take, pull-up history, read bytes
    always @(negedge clk) begin
        if (wr_take === 1'b1) begin
            widx = widx + 1;
        end
        wr_data = wbuf[widx % 4];
        pu_or = pu_or | strong_pullup_current;
        if (rd_valid === 1'b1) begin
            rq.push_back(rd_data);
        end
    end
    // --------
    // scenarios
    // --------
    initial begin
        rst_n = 1'b0;
        go = 1'b0;
        dev_addr = 7'h0;
        read = 1'b0;
        nbytes = 8'h0;
        wr_data = 8'h0;
        dev_reset_n = 1'b1;
        port_pins_in = 24'hffffff;
        {strap_hi, strap_mid, strap_lo} = 6'(rnd());
        own = addr_of(strap_hi, strap_mid, strap_lo);
        wbuf[0] = 8'h00;
        for (int i = 1; i < 4; i++) begin
            wbuf[i] = 8'(rnd());
        end
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(lat, 24'hffffff);
        chk(port_drive_low, 24'h0);
        chk(24'(int_line_n), 24'h1);
        // neighbouring strap address must stay unanswered
        xfer(own ^ 7'h01, 1'b0, 8'h1);
        chk(24'(nacked), 24'h1);
        chk(lat, 24'hffffff);
        flip();
        chk(24'(irq_seen), 24'h1);
        pu_or = 24'h0;
        // four bytes: the fourth wraps onto the first port
        xfer(own, 1'b0, 8'h4);
        chk(24'(nacked), 24'h0);
        chk(lat, {wbuf[2], wbuf[1], wbuf[3]});
        chk(port_drive_low, ~{wbuf[2], wbuf[1], wbuf[3]});
        chk(pu_or, {wbuf[2], wbuf[1], wbuf[0] | wbuf[3]});
        chk(24'(int_line_n), 24'h1);
        flip();
        // link reset puts every latch back to one before the pins are read
        @(negedge clk);
        dev_reset_n = 1'b0;
        repeat (10) @(negedge clk);
        chk(lat, 24'hffffff);
        dev_reset_n = 1'b1;
        repeat (10) @(negedge clk);
        chk(lat, 24'hffffff);
        rq.delete();
        // four bytes read: stop falls inside the second group
        xfer(own, 1'b1, 8'h4);
        chk(24'(rq.size()), 24'h4);
        chk({rq[2], rq[1], rq[0]}, port_pins_in);
        chk(24'(rq[3]), {16'h0, port_pins_in[7:0]});
        chk(24'(int_line_n), 24'h1);
        conclude();
    end
    initial begin
        #4000000;
        errors++;
        conclude();
    end
endmodule // i2c_quasi_bidir_port_expander_24_tb
`default_nettype wire
